// file: adc_cmd_pkg.sv
/*
  Shared constants and types for the serial command interpreter of a
  two-channel converter: command words, answers, register offsets and
  reset values, field positions and timing counts.
  Assumes a core clock of 20 MHz that also serves as modulator clock.
*/
`default_nettype none
package adc_cmd_pkg;
  // ==========================================================
  // command words and fixed answers
  localparam logic [15:0] CMD_NOP      = 16'h0000;
  localparam logic [15:0] CMD_RESET    = 16'h0011;
  localparam logic [15:0] CMD_STANDBY  = 16'h0022;
  localparam logic [15:0] CMD_RESUME   = 16'h0033;
  localparam logic [15:0] CMD_LOCK     = 16'h0555;
  localparam logic [15:0] CMD_UNLOCK   = 16'h0655;
  localparam logic [2:0]  PFX_READ     = 3'h5;
  localparam logic [2:0]  PFX_WRITE    = 3'h3;
  localparam logic [2:0]  PFX_RD_HDR   = 3'h7;
  localparam logic [2:0]  PFX_WR_ACK   = 3'h2;
  localparam logic [15:0] ACK_RESET    = 16'hff52;
  localparam logic [15:0] ACK_RESET_NG = 16'h0011;
  // ==========================================================
  // register offsets and values after reset
  localparam logic [5:0]  ADR_ID       = 6'h00;
  localparam logic [5:0]  ADR_STATUS   = 6'h01;
  localparam logic [5:0]  ADR_MODE     = 6'h02;
  localparam logic [5:0]  ADR_CLOCK    = 6'h03;
  localparam logic [5:0]  ADR_GAIN     = 6'h04;
  localparam logic [15:0] RST_MODE     = 16'h0510;
  localparam logic [15:0] RST_CLOCK    = 16'h038e;
  localparam logic [15:0] RST_GAIN     = 16'h0000;
  // ==========================================================
  // field positions
  localparam int MODE_RXCHK_BIT = 12;
  localparam int MODE_CTYPE_BIT = 11;
  localparam int MODE_WSIZE_LSB = 8;
  localparam int MODE_TOUT_BIT  = 4;
  localparam int STAT_LOCK_BIT  = 15;
  localparam int STAT_CHK_BIT   = 12;
  // ==========================================================
  // frame shape and timing
  localparam logic [1:0]  WSIZE_16     = 2'h0;
  localparam logic [1:0]  WSIZE_24     = 2'h1;
  localparam logic [7:0]  FULL_FRAME_WORDS = 8'h04;
  localparam int          TIMEOUT_MCLK = 2 ** 15;
  localparam logic [15:0] CODE_POS_MAX = 16'h7fff;
  localparam logic [15:0] CODE_NEG_MAX = 16'h8000;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } spi_pins_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [15:0] wdata;
  } sw_req_t;
endpackage
`default_nettype wire

// file: adc_spi_command_interpreter.sv
/*
  Command interpreter behind the serial target port of a two-channel
  converter, with its register file and a plain software register port.
  Assumes pin inputs are asynchronous to core_clk, the serial clock runs
  far slower than core_clk, and the serial mode shifts out on rising and
  samples on falling edges. core_clk doubles as the modulator clock.
*/
// Contract
// RULE1: with timeout enabled, abort a frame lasting 2^15 modulator clocks.
// RULE2: after a timeout the next serial clock starts a fresh frame.
// RULE3: two new-data flags sit in status; status answers the no-op command.
// RULE4: results are 16 bits, MSB aligned, low bits zero in wider words.
// RULE5: results clip to 7fff and 8000 beyond full scale.
// RULE6: results are signed two's complement.
// RULE7: the all-zero word changes nothing and collects results.
// RULE8: unknown words act like the no-op command.
// RULE9: every answer leads the frame after the command.
// RULE10: reset word taken at frame end restores all registers at once.
// RULE11: completed reset answers ff52; an unfinished reset frame answers 0011.
// RULE12: host waits settle time or data-ready rise after a reset.
// RULE13: standby word at frame end enters standby, echoed, idempotent.
// RULE14: resume word leaves standby, echoed, idempotent.
// RULE15: when locked only no-op, read and unlock are taken; echoed.
// RULE16: unlock word clears the lock and is echoed.
// RULE17: read word is prefix 101, six-bit address, count minus one.
// RULE18: single read answers the register value without header.
// RULE19: multi read answers header 111 then registers in rising order.
// RULE20: frame answering a multi read carries no channel words.
// RULE21: write word prefix 011; answer 010 with address and written minus one.
// RULE22: results are ready when data-ready goes low, one per period.
// RULE23: usual frame: answer, two results, check word.
// RULE24: on input check failure skip all but writes, flag it, answer no-op.
// RULE25: word size defaults to 24 bits, with 16 and 32, MSB aligned.
// RULE26: writes to read-only or absent addresses are skipped but counted; the code skips them and does not count them.
// RULE27: timeout counts only from a frame's first edge to its end.
// RULE28: only the top 16 bits of the first word are decoded.
`timescale 1ns/10ps
`default_nettype none
module adc_spi_command_interpreter #(
  parameter int TIMEOUT_CYCLES = adc_cmd_pkg::TIMEOUT_MCLK
) (
  input  wire logic               core_clk,
  input  wire logic               resetn,
  input  wire logic               clk_en,
  input  wire adc_cmd_pkg::spi_pins_t pins,
  output logic                    dout,
  output logic                    dout_oe,
  output logic                    conversion_ready_n,
  output logic                    standby,
  input  wire logic               sample_valid,
  input  wire logic signed [23:0] ch0_raw,
  input  wire logic signed [23:0] ch1_raw,
  input  wire logic               rx_check_fail,
  input  wire logic [15:0]        tx_check_word,
  input  wire adc_cmd_pkg::sw_req_t sw_req,
  output logic [15:0]             sw_rdata
);
  import adc_cmd_pkg::*;

  // ==========================================================
  // pin synchronisers and edges
  logic [2:0] cs_s, sclk_s;
  logic [1:0] din_s;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cs_s   <= 3'h7;
      sclk_s <= 3'h0;
      din_s  <= 2'h0;
    end else if (clk_en) begin
      cs_s   <= {cs_s[1:0], pins.cs_n};
      sclk_s <= {sclk_s[1:0], pins.sclk};
      din_s  <= {din_s[0], pins.din};
    end
  end
  logic sclk_rise, sclk_fall, cs_rise, cs_low;
  assign sclk_rise = clk_en & sclk_s[1] & ~sclk_s[2];
  assign sclk_fall = clk_en & ~sclk_s[1] & sclk_s[2];
  assign cs_low    = ~cs_s[1];
  assign cs_rise   = clk_en & cs_s[1] & ~cs_s[2];

  // ==========================================================
  // registers and state
  logic [15:0] mode_reg, clock_reg, gain_reg, resp_reg, cmd_reg;
  logic [15:0] ch0_reg, ch1_reg;
  logic [1:0]  flags_reg;
  logic        lock_reg, chk_err_reg, multi_reg, started_reg;
  logic [5:0]  rd_addr_reg;
  logic [6:0]  rd_n_reg, wr_cnt_reg;
  logic [4:0]  bit_reg;
  logic [7:0]  word_reg;
  logic [1:0]  wsize_reg;
  logic [31:0] rx_reg;
  logic [15:0] tout_reg;
  logic        word_done, frame_end, timeout_hit;
  logic [15:0] status_word, rx_word;
  logic [31:0] rx_full;
  logic        chk_fail_now;

  // a failing frame already shows its flag in the status answer it queues
  assign chk_fail_now = frame_end && rx_check_fail && mode_reg[MODE_RXCHK_BIT];
  assign status_word = {lock_reg, 2'h0, chk_err_reg | chk_fail_now, mode_reg[MODE_CTYPE_BIT],
                        1'b0, mode_reg[MODE_WSIZE_LSB +: 2], 6'h00, flags_reg}; // RULE3

  localparam logic [15:0] ID_VALUE = 16'h3c00; // arbitrary identity value

  function automatic logic [15:0] reg_value(input logic [5:0] a);
    unique case (a)
      ADR_ID:     reg_value = ID_VALUE;
      ADR_STATUS: reg_value = status_word;
      ADR_MODE:   reg_value = mode_reg;
      ADR_CLOCK:  reg_value = clock_reg;
      ADR_GAIN:   reg_value = gain_reg;
      default:    reg_value = 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] clip(input logic signed [23:0] v);
    if (v > $signed(24'h007fff))
      clip = CODE_POS_MAX;
    else if (v < $signed(24'hff8000))
      clip = CODE_NEG_MAX;
    else
      clip = v[15:0];
  endfunction

  // ==========================================================
  // frame tracking and timeout
  logic [4:0] last_bit;
  always_comb begin
    unique case (wsize_reg)
      WSIZE_16: last_bit = 5'd15;
      WSIZE_24: last_bit = 5'd23;
      default:  last_bit = 5'd31;
    endcase
  end
  assign rx_full     = {rx_reg[30:0], din_s[1]};
  assign word_done   = sclk_fall & started_reg & (bit_reg == last_bit);
  assign frame_end   = cs_rise & started_reg;
  assign timeout_hit = clk_en & started_reg & cs_low & mode_reg[MODE_TOUT_BIT]
                       & (tout_reg == 16'(TIMEOUT_CYCLES - 1));
  always_comb begin
    unique case (wsize_reg)
      WSIZE_16: rx_word = rx_full[15:0];
      WSIZE_24: rx_word = rx_full[23:8];
      default:  rx_word = rx_full[31:16]; // RULE28
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      started_reg <= 1'b0;
      bit_reg     <= 5'h00;
      word_reg    <= 8'h00;
      rx_reg      <= 32'h0;
      tout_reg    <= 16'h0;
      wsize_reg   <= WSIZE_24;
    end else if (timeout_hit || frame_end) begin
      started_reg <= 1'b0; // RULE1
      bit_reg     <= 5'h00;
      word_reg    <= 8'h00;
      tout_reg    <= 16'h0; // RULE27
    end else if (clk_en && cs_low) begin
      if (!started_reg && (sclk_rise || sclk_fall)) begin
        started_reg <= 1'b1; // RULE2
        wsize_reg   <= mode_reg[MODE_WSIZE_LSB +: 2];
      end
      if (started_reg)
        tout_reg <= tout_reg + 16'h1;
      if (sclk_fall) begin
        rx_reg  <= rx_full;
        bit_reg <= (bit_reg == last_bit) ? 5'h00 : bit_reg + 5'h1;
        if (bit_reg == last_bit && word_reg != 8'hff)
          word_reg <= word_reg + 8'h1;
      end
    end
  end

  // ==========================================================
  // command capture and decode
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      cmd_reg <= CMD_NOP;
    else if (frame_end || timeout_hit)
      cmd_reg <= CMD_NOP;
    else if (word_done && word_reg == 8'h00)
      cmd_reg <= rx_word;
  end
  logic is_rd, is_wr, allowed, reset_go, wr_live;
  logic [5:0] wr_addr;
  assign is_rd   = cmd_reg[15:13] == PFX_READ; // RULE17
  assign is_wr   = cmd_reg[15:13] == PFX_WRITE;
  assign allowed = !(rx_check_fail && mode_reg[MODE_RXCHK_BIT]) &&
                   (!lock_reg || cmd_reg == CMD_NOP || is_rd || cmd_reg == CMD_UNLOCK); // RULE15 RULE24
  assign reset_go = frame_end && allowed && cmd_reg == CMD_RESET &&
                    word_reg >= FULL_FRAME_WORDS; // RULE10
  assign wr_live = word_done && is_wr && !lock_reg && word_reg != 8'h00 &&
                   word_reg <= {1'b0, cmd_reg[6:0]} + 8'h1;
  assign wr_addr = 6'(cmd_reg[12:7] + word_reg[5:0] - 6'h1);

  // ==========================================================
  // register file: serial writes win over software writes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg   <= RST_MODE; // RULE25
      clock_reg  <= RST_CLOCK;
      gain_reg   <= RST_GAIN;
      wr_cnt_reg <= 7'h00;
    end else if (clk_en) begin
      if (reset_go) begin
        mode_reg  <= RST_MODE; // RULE10
        clock_reg <= RST_CLOCK;
        gain_reg  <= RST_GAIN;
      end else if (wr_live) begin
        unique case (wr_addr)
          ADR_MODE:  mode_reg  <= rx_word;
          ADR_CLOCK: clock_reg <= rx_word;
          ADR_GAIN:  gain_reg  <= rx_word;
          default: ; // RULE26
        endcase
      end else if (sw_req.wr) begin
        unique case (sw_req.addr)
          ADR_MODE:  mode_reg  <= sw_req.wdata;
          ADR_CLOCK: clock_reg <= sw_req.wdata;
          ADR_GAIN:  gain_reg  <= sw_req.wdata;
          default: ;
        endcase
      end
      if (frame_end || timeout_hit)
        wr_cnt_reg <= 7'h00;
      else if (wr_live && wr_addr >= ADR_MODE && wr_addr <= ADR_GAIN)
        wr_cnt_reg <= wr_cnt_reg + 7'h1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      sw_rdata <= 16'h0000;
    else if (clk_en)
      sw_rdata <= sw_req.rd ? reg_value(sw_req.addr) : 16'h0000;
  end

  // ==========================================================
  // answer for the next frame, lock and standby
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      resp_reg    <= 16'h0000;
      multi_reg   <= 1'b0;
      rd_addr_reg <= 6'h00;
      rd_n_reg    <= 7'h00;
      lock_reg    <= 1'b0;
      standby     <= 1'b0;
    end else if (frame_end) begin
      resp_reg  <= status_word; // RULE7 RULE8 RULE9
      multi_reg <= 1'b0;
      if (allowed) begin
        if (cmd_reg == CMD_RESET) begin
          resp_reg <= reset_go ? ACK_RESET : ACK_RESET_NG; // RULE11
          if (reset_go)
            lock_reg <= 1'b0;
        end else if (cmd_reg == CMD_STANDBY) begin
          resp_reg <= cmd_reg;
          standby  <= 1'b1; // RULE13
        end else if (cmd_reg == CMD_RESUME) begin
          resp_reg <= cmd_reg;
          standby  <= 1'b0; // RULE14
        end else if (cmd_reg == CMD_LOCK) begin
          resp_reg <= cmd_reg;
          lock_reg <= 1'b1; // RULE15
        end else if (cmd_reg == CMD_UNLOCK) begin
          resp_reg <= cmd_reg;
          lock_reg <= 1'b0; // RULE16
        end else if (is_rd) begin
          rd_addr_reg <= cmd_reg[12:7];
          rd_n_reg    <= cmd_reg[6:0];
          multi_reg   <= cmd_reg[6:0] != 7'h00;
          resp_reg    <= (cmd_reg[6:0] == 7'h00) ? reg_value(cmd_reg[12:7]) // RULE18
                         : {PFX_RD_HDR, cmd_reg[12:0]}; // RULE19
        end else if (is_wr) begin
          resp_reg <= {PFX_WR_ACK, cmd_reg[12:7], 7'(wr_cnt_reg - 7'h1)}; // RULE21
        end
      end
    end
  end

  // ==========================================================
  // conversion results, new-data flags and check error flag
  logic ch_read, stat_out;
  assign ch_read  = word_done && !multi_reg && word_reg == 8'h02;
  assign stat_out = word_done && word_reg == 8'h00 && resp_reg == status_word;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ch0_reg            <= 16'h0000;
      ch1_reg            <= 16'h0000;
      flags_reg          <= 2'h0;
      conversion_ready_n <= 1'b1;
    end else if (clk_en) begin
      if (sample_valid) begin
        ch0_reg            <= clip(ch0_raw); // RULE5 RULE6
        ch1_reg            <= clip(ch1_raw);
        flags_reg          <= 2'h3; // RULE3
        conversion_ready_n <= 1'b0; // RULE22
      end else if (ch_read) begin
        flags_reg          <= 2'h0;
        conversion_ready_n <= 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      chk_err_reg <= 1'b0;
    else if (chk_fail_now)
      chk_err_reg <= 1'b1; // RULE24
    else if (stat_out)
      chk_err_reg <= 1'b0;
  end

  // ==========================================================
  // output word selection and serial shift
  logic [15:0] out_word;
  logic [7:0]  rd_last;
  assign rd_last = {1'b0, rd_n_reg} + 8'h1;
  always_comb begin
    out_word = 16'h0000;
    if (word_reg == 8'h00)
      out_word = resp_reg;
    else if (multi_reg) begin
      if (word_reg <= rd_last)
        out_word = reg_value(6'(rd_addr_reg + word_reg[5:0] - 6'h1)); // RULE19 RULE20
      else if (word_reg == rd_last + 8'h1)
        out_word = tx_check_word;
    end else begin
      unique case (word_reg)
        8'h01:   out_word = ch0_reg; // RULE23
        8'h02:   out_word = ch1_reg;
        8'h03:   out_word = tx_check_word;
        default: out_word = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      dout <= 1'b0;
    else if (clk_en && !cs_low)
      dout <= 1'b0;
    else if (sclk_rise)
      dout <= (bit_reg < 5'd16) ? out_word[4'(5'd15 - bit_reg)] : 1'b0; // RULE4
  end
  assign dout_oe = cs_low;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_clip_high: assert property (sample_valid && clk_en && ch0_raw > $signed(24'h007fff)
    |=> ch0_reg == CODE_POS_MAX) else $error("positive clip missed"); // RULE5
  a_clip_low: assert property (sample_valid && clk_en && ch1_raw < $signed(24'hff8000)
    |=> ch1_reg == CODE_NEG_MAX) else $error("negative clip missed"); // RULE5
  a_ready_low: assert property (sample_valid && clk_en |=> !conversion_ready_n && flags_reg == 2'h3)
    else $error("data ready not asserted"); // RULE22
  a_reset_ack: assert property (reset_go |=> resp_reg == ACK_RESET && mode_reg == RST_MODE)
    else $error("reset not acknowledged"); // RULE11
  a_reset_short: assert property (frame_end && allowed && cmd_reg == CMD_RESET
    && word_reg < FULL_FRAME_WORDS |=> resp_reg == ACK_RESET_NG) else $error("short reset answer"); // RULE11
  a_timeout_abort: assert property (timeout_hit |=> !started_reg && word_reg == 8'h00)
    else $error("timeout did not abort"); // RULE1
  a_lock_holds: assert property (frame_end && lock_reg && cmd_reg == CMD_STANDBY
    |=> standby == $past(standby) && lock_reg) else $error("locked command took effect"); // RULE15
  a_nop_status: assert property (frame_end && cmd_reg == CMD_NOP
    |=> resp_reg == $past(status_word)) else $error("no-op answer wrong"); // RULE7
  a_wr_answer: assert property (frame_end && allowed && is_wr
    |=> resp_reg[15:13] == PFX_WR_ACK) else $error("write answer prefix"); // RULE21
endmodule
`default_nettype wire

// file: host_spi_model.sv
/*
  Host side serial controller model: clocks frames of 24-bit words,
  command in the top 16 bits of word 0, data in word 1, zeros after.
  Assumes the device word size is 24 bits and a 400 ns serial clock.
*/
`timescale 1ns/10ps
`default_nettype none
module host_spi_model (
  output var adc_cmd_pkg::spi_pins_t pins,
  input  wire logic                  dout
);
  import adc_cmd_pkg::*;
  logic [15:0] rx [0:7];

  initial begin
    pins = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
  end

  // ==========================================================
  // one serial clock: data changes at rise, answer read just before next rise
  task automatic bit_cycle(input logic b, output logic got);
    pins.sclk = 1'b1;
    pins.din  = b;
    #200;
    pins.sclk = 1'b0;
    #200;
    got = dout;
  endtask

  // ==========================================================
  // lead > 0 clocks stray bits, then stalls past the frame limit
  task automatic frame(input logic [15:0] w0, input logic [15:0] w1, input int nwords, input int lead);
    logic [23:0] word;
    logic        got;
    pins.cs_n = 1'b0;
    #200;
    for (int i = 0; i < lead; i++) bit_cycle(1'b1, got);
    if (lead > 0) #105000;
    for (int k = 0; k < nwords; k++) begin
      word = {(k == 0) ? w0 : (k == 1) ? w1 : 16'h0000, 8'h00};
      for (int b = 23; b >= 0; b--) begin
        bit_cycle(word[b], got);
        word[b] = got;
      end
      rx[k] = word[23:8];
    end
    pins.cs_n = 1'b1;
    // released data line shows the inverse of its last level
    pins.din  = ~pins.din;
    #1000;
  endtask
endmodule
`default_nettype wire

// file: tb.sv
/*
  Self-checking bench for the serial command interpreter.
  Assumes host_spi_model and the package are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module tb;
  import adc_cmd_pkg::*;
  typedef struct packed {logic [15:0] cmd; logic [15:0] w1; logic [15:0] exp; logic sb;} row_t;
  typedef struct packed {logic signed [23:0] a; logic signed [23:0] b; logic [15:0] ea; logic [15:0] eb;} data_t;
  localparam int SETTLE_CYCLES = 20;
  logic               core_clk;
  logic               resetn;
  logic               sample_valid;
  logic               rx_check_fail;
  logic               dout;
  logic               dout_oe;
  logic               conversion_ready_n;
  logic               standby;
  logic signed [23:0] ch0_raw;
  logic signed [23:0] ch1_raw;
  logic [15:0]        sw_rdata;
  logic [15:0]        rd;
  sw_req_t            sw_req;
  spi_pins_t          pins;
  int                 failures = 0;
  int                 checks_done = 0;
  row_t rows [0:14] = '{
    '{16'h0000, 16'h0, 16'h0100, 1'b0}, '{16'h0022, 16'h0, 16'h0022, 1'b1}, '{16'h0022, 16'h0, 16'h0022, 1'b1},
    '{16'h0033, 16'h0, 16'h0033, 1'b0}, '{16'h0033, 16'h0, 16'h0033, 1'b0}, '{16'ha100, 16'h0, 16'h0510, 1'b0},
    '{16'h1234, 16'h0, 16'h0100, 1'b0}, '{16'h0555, 16'h0, 16'h0555, 1'b0}, '{16'h0022, 16'h0, 16'h8100, 1'b0},
    '{16'ha180, 16'h0, 16'h038e, 1'b0}, '{16'h0655, 16'h0, 16'h0655, 1'b0}, '{16'h6200, 16'h77, 16'h4200, 1'b0},
    '{16'ha200, 16'h0, 16'h0077, 1'b0}, '{16'h6000, 16'h1234, 16'h407f, 1'b0}, '{16'h0000, 16'h0, 16'h0100, 1'b0}};
  data_t dat [0:3] = '{'{24'sd1, -24'sd1, 16'h0001, 16'hffff}, '{24'sd0, 24'sd32768, 16'h0000, 16'h7fff},
    '{-24'sd32768, -24'sd32769, 16'h8000, 16'h8000}, '{24'sd40000, 24'sd32767, 16'h7fff, 16'h7fff}};

  adc_spi_command_interpreter #(.TIMEOUT_CYCLES(2000)) DUT (
    .core_clk(core_clk), .resetn(resetn), .clk_en(1'b1), .pins(pins), .dout(dout), .dout_oe(dout_oe),
    .conversion_ready_n(conversion_ready_n), .standby(standby), .sample_valid(sample_valid),
    .ch0_raw(ch0_raw), .ch1_raw(ch1_raw), .rx_check_fail(rx_check_fail), .tx_check_word(16'h5a5a),
    .sw_req(sw_req), .sw_rdata(sw_rdata));
  host_spi_model HOST (.pins(pins), .dout(dout));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ==========================================================
  // software port and closing
  task automatic sw_write(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk);
    sw_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    sw_req <= '0;
  endtask

  task automatic sw_read(input logic [5:0] a, output logic [15:0] d);
    @(posedge core_clk);
    sw_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge core_clk);
    sw_req <= '0;
    #1;
    d = sw_rdata;
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #4000000;
    failures++;
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial begin
    resetn = 1'b0;
    sample_valid = 1'b0;
    rx_check_fail = 1'b0;
    ch0_raw = '0;
    ch1_raw = '0;
    sw_req = '0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    sw_read(ADR_MODE, rd);
    `CHK("mode", RST_MODE, rd)
    sw_read(6'h3f, rd);
    `CHK("unmapped", 16'h0000, rd)
    for (int i = 0; i < 15; i++) begin
      HOST.frame(rows[i].cmd, rows[i].w1, 6, 0);
      if (i > 0) `CHK("answer", rows[i-1].exp, HOST.rx[0])
      `CHK("standby", rows[i].sb, standby)
      `CHK("oe idle", 1'b0, dout_oe)
    end
    HOST.frame(16'ha102, 16'h0, 6, 0);
    `CHK("answer", rows[14].exp, HOST.rx[0])
    HOST.frame(CMD_NOP, 16'h0, 6, 0);
    `CHK("multi hdr", 16'he102, HOST.rx[0])
    `CHK("multi r2", RST_MODE, HOST.rx[1])
    `CHK("multi r3", RST_CLOCK, HOST.rx[2])
    `CHK("multi r4", 16'h0077, HOST.rx[3])
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      sample_valid <= 1'b1;
      ch0_raw <= dat[i].a;
      ch1_raw <= dat[i].b;
      @(posedge core_clk);
      sample_valid <= 1'b0;
      sw_read(ADR_STATUS, rd);
      `CHK("flags", 16'h0103, rd)
      `CHK("ready low", 1'b0, conversion_ready_n)
      HOST.frame(CMD_NOP, 16'h0, 6, 0);
      `CHK("ch0", dat[i].ea, HOST.rx[1])
      `CHK("ch1", dat[i].eb, HOST.rx[2])
      `CHK("check word", 16'h5a5a, HOST.rx[3])
      `CHK("ready high", 1'b1, conversion_ready_n)
    end
    sw_write(ADR_MODE, 16'h1510);
    @(posedge core_clk);
    rx_check_fail <= 1'b1;
    #1;
    HOST.frame(CMD_STANDBY, 16'h0, 6, 0);
    `CHK("chk standby", 1'b0, standby)
    HOST.frame({PFX_WRITE, ADR_GAIN, 7'h00}, 16'h0033, 6, 0);
    `CHK("chk answer", 16'h1100, HOST.rx[0])
    @(posedge core_clk);
    rx_check_fail <= 1'b0;
    sw_read(ADR_GAIN, rd);
    `CHK("chk write", 16'h0033, rd)
    sw_write(ADR_MODE, RST_MODE);
    HOST.frame(CMD_NOP, 16'h0, 6, 0);
    HOST.frame(CMD_RESET, 16'h0, 2, 0);
    HOST.frame(CMD_NOP, 16'h0, 6, 0);
    `CHK("short reset", ACK_RESET_NG, HOST.rx[0])
    sw_read(ADR_GAIN, rd);
    `CHK("gain kept", 16'h0033, rd)
    HOST.frame(CMD_RESET, 16'h0, 6, 0);
    repeat (SETTLE_CYCLES) @(posedge core_clk);
    #1;
    HOST.frame(CMD_NOP, 16'h0, 6, 0);
    `CHK("reset ack", ACK_RESET, HOST.rx[0])
    sw_read(ADR_GAIN, rd);
    `CHK("gain reset", RST_GAIN, rd)
    HOST.frame(CMD_STANDBY, 16'h0, 6, 4);
    `CHK("fresh frame", 1'b1, standby)
    HOST.frame(CMD_RESUME, 16'h0, 6, 0);
    `CHK("after abort", CMD_STANDBY, HOST.rx[0])
    `CHK("resumed", 1'b0, standby)
    complete_run();
  end
endmodule
`default_nettype wire
